// File: include/icc_map.svh
// Register offsets, field positions, reset values of the capture channel
// Assumes a 32-bit APB slave with byte addresses in paddr
`ifndef ICC_MAP_SVH
`define ICC_MAP_SVH

`define ICC_ADDR_W 8
`define ICC_OFF_CTRL 8'h00
`define ICC_OFF_BUF 8'h04
`define ICC_OFF_ISTAT 8'h08
`define ICC_OFF_IMASK 8'h0C

`define ICC_IDLE_STOP_BIT 13
`define ICC_TSEL_MSB 12
`define ICC_TSEL_LSB 10
`define ICC_ICI_MSB 6
`define ICC_ICI_LSB 5
`define ICC_OVF_BIT 4
`define ICC_BNE_BIT 3
`define ICC_MODE_MSB 2
`define ICC_MODE_LSB 0

`define ICC_CTRL_WMASK 16'h3C67
`define ICC_CTRL_RESET 16'h0000

`define ICC_IST_W 3
`define ICC_IST_CAP_BIT 0
`define ICC_IST_OVF_BIT 1
`define ICC_IST_WAKE_BIT 2
`define ICC_IST_RESET 3'h0
`define ICC_IMASK_RESET 3'h0

`define ICC_DIV4_LAST 4'h3
`define ICC_DIV16_LAST 4'hF

`endif

// File: include/icc_pkg.sv
// Types shared by the capture channel modules
// Assumes the constants header supplies all numeric positions
package icc_pkg;

    typedef enum logic [2:0] {
        ICC_M_OFF    = 3'h0,
        ICC_M_BOTH   = 3'h1,
        ICC_M_FALL   = 3'h2,
        ICC_M_RISE   = 3'h3,
        ICC_M_DIV4   = 3'h4,
        ICC_M_DIV16  = 3'h5,
        ICC_M_UNUSED = 3'h6,
        ICC_M_PIN    = 3'h7
    } icc_mode_e;

    typedef enum logic [2:0] {
        ICC_T_TMR3   = 3'h0,
        ICC_T_TMR2   = 3'h1,
        ICC_T_TMR4   = 3'h2,
        ICC_T_TMR5   = 3'h3,
        ICC_T_TMR1   = 3'h4,
        ICC_T_RSV5   = 3'h5,
        ICC_T_RSV6   = 3'h6,
        ICC_T_PERIPH = 3'h7
    } icc_tsel_e;

    typedef enum logic [2:0] {
        ICC_S_IDLE = 3'b001,
        ICC_S_WAIT = 3'b010,
        ICC_S_RESP = 3'b100
    } icc_apb_state_e;

endpackage

// File: src/icc_sync.sv
// Two-flop synchroniser for the capture pin with edge pulses
// Assumes an asynchronous pin and one clock domain
module icc_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic rise,
    output logic fall
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign rise = sync_q & ~last_q;
    assign fall = ~sync_q & last_q;
endmodule

// File: src/icc_buf.sv
// Capture buffer storage, registered read port
// Assumes pointers are kept by the caller
module icc_buf #(
    parameter int W = 16,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// File: src/icc_top.sv
// Input capture channel: control register, edge capture, buffer, interrupt
// Assumes APB master on pclk; timer counts arrive synchronous to pclk
`include "icc_map.svh"

module icc_top #(
    parameter int CNT_W = 16,
    parameter int DEPTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ICC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_pin,
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    input wire logic [CNT_W-1:0] timer_one_count,
    input wire logic [CNT_W-1:0] timer_two_count,
    input wire logic [CNT_W-1:0] timer_three_count,
    input wire logic [CNT_W-1:0] timer_four_count,
    input wire logic [CNT_W-1:0] timer_five_count,
    output logic irq
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
            $error("icc_top: CNT_W must be 1..32");
        end
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("icc_top: DEPTH must be a power of two >= 2");
        end
        // Status and unimplemented bits must stay out of the write mask
        if (`ICC_IST_W != 3 || (`ICC_CTRL_WMASK & 16'hC398) != 16'h0000) begin : g_bad_map
            $error("icc_top: header constants do not fit this logic");
        end
    endgenerate

    // Register state
    logic [15:0] ctrl_q;
    logic [`ICC_IST_W-1:0] ist_q;
    logic [`ICC_IST_W-1:0] imask_q;
    logic ovf_q;
    logic [AW:0] wr_ptr_q;
    logic [AW:0] rd_ptr_q;
    logic [3:0] presc_q;
    logic [1:0] icnt_q;
    logic [CNT_W-1:0] periph_cnt_q;
    icc_pkg::icc_apb_state_e st_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;

    // Pin edges
    logic pin_rise;
    logic pin_fall;

    icc_sync u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .async_in(capture_pin),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // Control fields
    wire idle_stop = ctrl_q[`ICC_IDLE_STOP_BIT];
    wire [2:0] tsel = ctrl_q[`ICC_TSEL_MSB:`ICC_TSEL_LSB];
    wire [1:0] captures_per_interrupt = ctrl_q[`ICC_ICI_MSB:`ICC_ICI_LSB];
    wire [2:0] mode = ctrl_q[`ICC_MODE_MSB:`ICC_MODE_LSB];

    wire m_off = (mode == icc_pkg::ICC_M_OFF);
    wire m_unused = (mode == icc_pkg::ICC_M_UNUSED);
    wire m_both = (mode == icc_pkg::ICC_M_BOTH);
    wire m_fall = (mode == icc_pkg::ICC_M_FALL);
    wire m_rise = (mode == icc_pkg::ICC_M_RISE);
    wire m_div4 = (mode == icc_pkg::ICC_M_DIV4);
    wire m_div16 = (mode == icc_pkg::ICC_M_DIV16);
    wire m_pin = (mode == icc_pkg::ICC_M_PIN);
    wire m_disabled = m_off | m_unused;

    // Capture halts in CPU idle only when asked to
    wire halted = idle_stop & cpu_idle;
    wire run = ~halted & ~m_disabled;

    // Edge qualification per mode
    wire hit_both = m_both & (pin_rise | pin_fall);
    wire hit_rise = m_rise & pin_rise;
    wire hit_fall = m_fall & pin_fall;
    wire hit_div = (m_div4 | m_div16) & pin_rise;
    wire edge_hit = run & (hit_both | hit_rise | hit_fall | hit_div);

    wire [3:0] presc_last = m_div16 ? `ICC_DIV16_LAST : `ICC_DIV4_LAST;
    wire presc_wrap = (presc_q == presc_last);
    wire cap_evt = edge_hit & (~hit_div | presc_wrap);

    // Wake pin ignores every other control field, including idle-stop
    wire wake_evt = m_pin & (cpu_sleep | cpu_idle) & pin_rise;

    // Timebase selection
    logic [CNT_W-1:0] ts_val;

    always_comb begin
        case (tsel)
            icc_pkg::ICC_T_PERIPH: ts_val = periph_cnt_q;
            icc_pkg::ICC_T_TMR1: ts_val = timer_one_count;
            icc_pkg::ICC_T_TMR5: ts_val = timer_five_count;
            icc_pkg::ICC_T_TMR4: ts_val = timer_four_count;
            icc_pkg::ICC_T_TMR2: ts_val = timer_two_count;
            icc_pkg::ICC_T_TMR3: ts_val = timer_three_count;
            default: ts_val = '0;
        endcase
    end

    // Buffer pointers and status
    wire [AW:0] fill = wr_ptr_q - rd_ptr_q;
    wire buf_empty = (wr_ptr_q == rd_ptr_q);
    wire buf_full = (fill == (AW + 1)'(DEPTH));
    wire push = cap_evt & ~buf_full;
    wire ovf_set = cap_evt & buf_full;
    logic [CNT_W-1:0] buf_rd_data;

    icc_buf #(
        .W(CNT_W),
        .DEPTH(DEPTH)
    ) u_buf (
        .clk(pclk),
        .wr_en(push),
        .wr_addr(wr_ptr_q[AW-1:0]),
        .wr_data(ts_val),
        .rd_addr(rd_ptr_q[AW-1:0]),
        .rd_data(buf_rd_data)
    );

    // APB decode
    wire addr_ctrl = (paddr == `ICC_OFF_CTRL);
    wire addr_buf = (paddr == `ICC_OFF_BUF);
    wire addr_ist = (paddr == `ICC_OFF_ISTAT);
    wire addr_imask = (paddr == `ICC_OFF_IMASK);
    wire addr_hit = addr_ctrl | addr_buf | addr_ist | addr_imask;

    // Access phase as seen by the slave
    wire apb_access = psel & penable;

    wire acc_done = (st_q == icc_pkg::ICC_S_RESP) & apb_access;
    wire wr_ok = acc_done & pwrite & addr_hit;
    wire rd_ok = acc_done & ~pwrite & addr_hit;
    wire ctrl_wr = wr_ok & addr_ctrl;
    wire imask_wr = wr_ok & addr_imask;
    wire pop = rd_ok & addr_buf & ~buf_empty;
    wire ist_rd = rd_ok & addr_ist;

    // Unimplemented bits come back as zero
    wire [15:0] ctrl_view = {ctrl_q[15:5], ovf_q, ~buf_empty, ctrl_q[2:0]};
    wire [31:0] buf_view = buf_empty ? 32'h0000_0000 : 32'(buf_rd_data);
    wire [31:0] rd_mux = addr_ctrl ? {16'h0000, ctrl_view} :
                         addr_buf ? buf_view :
                         addr_ist ? {29'h0000_0000, ist_q} :
                         addr_imask ? {29'h0000_0000, imask_q} :
                         32'h0000_0000;

    // Interrupt rate; both-edge mode fires on every capture
    wire ici_ignored = m_both | m_pin;
    wire rate_hit = ici_ignored | (icnt_q == captures_per_interrupt);
    wire cap_int = cap_evt & rate_hit;

    // Event order matches the status and mask layout
    wire [`ICC_IST_W-1:0] ist_set = {wake_evt, ovf_set, cap_int};
    // Set beats the read-clear in the same cycle
    wire [`ICC_IST_W-1:0] ist_d = (ist_rd ? {`ICC_IST_W{1'b0}} : ist_q) | ist_set;
    wire [`ICC_IST_W-1:0] imask_d = imask_wr ? pwdata[`ICC_IST_W-1:0] : imask_q;

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `ICC_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= pwdata[15:0] & `ICC_CTRL_WMASK;
        end
    end

    // Free-running peripheral clock count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_cnt_q <= '0;
        end else begin
            periph_cnt_q <= periph_cnt_q + 1'b1;
        end
    end

    // Prescaler restarts whenever the control register is written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= 4'h0;
        end else if (ctrl_wr || m_disabled) begin
            presc_q <= 4'h0;
        end else if (edge_hit && hit_div) begin
            presc_q <= presc_wrap ? 4'h0 : presc_q + 4'h1;
        end
    end

    // Captures-per-interrupt counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            icnt_q <= 2'h0;
        end else if (ctrl_wr || m_disabled) begin
            icnt_q <= 2'h0;
        end else if (cap_evt) begin
            icnt_q <= rate_hit ? 2'h0 : icnt_q + 2'h1;
        end
    end

    // Buffer pointers; a disabled channel discards stored captures
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_q <= '0;
        end else if (m_disabled) begin
            wr_ptr_q <= '0;
        end else if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
        end
    end

    // Read side advances only on a completed read of a non-empty buffer, and clears when the channel is disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr_q <= '0;
        end else if (m_disabled) begin
            rd_ptr_q <= '0;
        end else if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end

    // Overflow flag: set by a lost capture, cleared once the buffer drains
    wire drain = pop & (fill == (AW + 1)'(1)) & ~push;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_q <= 1'b0;
        end else if (ovf_set) begin
            ovf_q <= 1'b1;
        end else if (drain || m_disabled) begin
            ovf_q <= 1'b0;
        end
    end

    // Interrupt status, mask and output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_q <= `ICC_IST_RESET;
        end else begin
            ist_q <= ist_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask_q <= `ICC_IMASK_RESET;
        end else begin
            imask_q <= imask_d;
        end
    end

    // Built from next values so the output never lags a status bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(ist_d & imask_d);
        end
    end

    // APB slave: one wait state, answer on the second access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= icc_pkg::ICC_S_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            case (st_q)
                icc_pkg::ICC_S_IDLE: begin
                    pready_q <= 1'b0;
                    pslverr_q <= 1'b0;
                    if (psel) begin
                        st_q <= icc_pkg::ICC_S_WAIT;
                    end
                end
                icc_pkg::ICC_S_WAIT: begin
                    if (apb_access) begin
                        st_q <= icc_pkg::ICC_S_RESP;
                        pready_q <= 1'b1;
                        pslverr_q <= ~addr_hit;
                        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
                    end else if (!psel) begin
                        st_q <= icc_pkg::ICC_S_IDLE;
                    end
                end
                icc_pkg::ICC_S_RESP: begin
                    st_q <= icc_pkg::ICC_S_IDLE;
                    pready_q <= 1'b0;
                    pslverr_q <= 1'b0;
                end
                default: begin
                    st_q <= icc_pkg::ICC_S_IDLE;
                    pready_q <= 1'b0;
                    pslverr_q <= 1'b0;
                end
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
endmodule

// File: tb/icc_pin_model.sv
// Far-side source driving the capture pin with a burst of square pulses
// Assumes one pulse is 4 pclk high then 4 low; pin rests low between bursts
module icc_pin_model (
    input wire logic pclk,
    input wire logic [7:0] pulses,
    input wire logic go,
    output logic capture_pin,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [10:0] cnt_q = 11'h000;
    logic busy_q = 1'h0;
    // Counting down, bit 2 gives exactly one rising and one falling edge per 8 counts
    always @(posedge pclk) begin
        if (go && !busy_q) begin
            busy_q <= 1'h1;
            cnt_q <= {pulses, 3'h0};
        end else if (cnt_q != 11'h000) begin
            cnt_q <= cnt_q - 11'h001;
        end else begin
            busy_q <= 1'h0;
        end
    end
    assign capture_pin = cnt_q[2];
    assign busy = busy_q;
endmodule

// File: tb/icc_top_assertions.sv
// APB timing and control read-back checks of the capture channel
// Assumes the master idles one cycle between transfers
`include "icc_map.svh"
module icc_top_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ICC_ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wait_state_a: assert property (psel && !penable |=> !pready ##1 pready) else $error("no single wait state");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    ready_cause_a: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready without access phase");
    err_map_a: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h0C))
        else $error("pslverr wrong for address");
    ctrl_rsvd_a: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata[31:14] == 18'h0_0000 &&
        prdata[9:7] == 3'h0) else $error("unused control bits not zero");
    off_empty_a: assert property (pready && !pwrite && paddr == 8'h00 &&
        (prdata[2:0] == 3'h0 || prdata[2:0] == 3'h6) |-> prdata[4:3] == 2'h0) else $error("status set while off");
    pin_mode_a: assert property (pready && !pwrite && paddr == 8'h00 && prdata[2:0] == 3'h7 |-> !prdata[3])
        else $error("capture stored in pin mode");
    ovf_bne_a: assert property (pready && !pwrite && paddr == 8'h00 && prdata[4] |-> prdata[3])
        else $error("overflow with empty buffer");
    stat_width_a: assert property (pready && !pwrite && paddr[3] |-> prdata[31:3] == 29'h0000_0000)
        else $error("status word too wide");
    write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0000_0000) else $error("read data on write");
endmodule
bind icc_top icc_top_checker u_icc_top_checker (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr);

// File: tb/tb_top.sv
// Self-checking bench: APB master, pin bursts, buffer drain, status and interrupt
// Assumes timer counts held steady during a burst so captured values are known
`include "icc_map.svh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin failures++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DEPTH = 4;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic go = 1'h0, cpu_idle = 1'h0, cpu_sleep = 1'h0, erv, pready, pslverr, irq, capture_pin, busy;
    logic [7:0] paddr = 8'h00, npulse = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, seed = 32'h0000_100c, prdata, rdv;
    logic [15:0] tmr [1:5] = '{default: 16'h0000};
    int failures = 0, comparisons = 0;
    initial begin
        forever #50 pclk = ~pclk;
    end
    icc_top #(.CNT_W(16), .DEPTH(DEPTH)) u_icc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_pin(capture_pin), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
        .timer_one_count(tmr[1]), .timer_two_count(tmr[2]), .timer_three_count(tmr[3]),
        .timer_four_count(tmr[4]), .timer_five_count(tmr[5]), .irq(irq));
    icc_pin_model u_icc_pin_model (.pclk(pclk), .pulses(npulse), .go(go), .capture_pin(capture_pin), .busy(busy));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'h0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0000_0000);
    endfunction
    function automatic int exp_caps(input logic [2:0] m, input int n, input logic halt);
        if (halt && m != 3'h7) return 0;
        case (m)
            3'h1: return 2 * n;
            3'h2, 3'h3: return n;
            3'h4: return n / 4;
            3'h5: return n / 16;
            default: return 0;
        endcase
    endfunction
    function automatic logic [15:0] exp_val(input logic [2:0] t);
        case (t)
            3'h0: return tmr[3];
            3'h1: return tmr[2];
            3'h2: return tmr[4];
            3'h3: return tmr[5];
            3'h4: return tmr[1];
            default: return 16'h0000;
        endcase
    endfunction
    task tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        int i;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'h1 && i < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (i >= 20) begin
            failures++;
            tally_and_finish();
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d, rdv, erv);
    endtask
    task chk_rd(input string n, input logic [7:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0000_0000, rdv, erv);
        `CHK(n, x, rdv)
    endtask
    task automatic run_case(input logic [2:0] m, input logic [2:0] t, input logic [1:0] captures_per_interrupt, input logic stop,
        input int n);
        logic [15:0] c;
        logic [2:0] ist, msk;
        logic [15:0] prev;
        int caps, i;
        c = {2'h0, stop, t, 3'h0, captures_per_interrupt, 2'h0, m};
        @(posedge pclk);
        for (i = 1; i <= 5; i++) begin
            seed = lfsr(seed);
            tmr[i] <= seed[15:0];
        end
        msk = seed[18:16];
        npulse <= n[7:0];
        wr(`ICC_OFF_CTRL, 32'h0000_0000);
        wr(`ICC_OFF_IMASK, {29'h0000_0000, msk});
        apb(1'h0, `ICC_OFF_ISTAT, 32'h0000_0000, rdv, erv);
        wr(`ICC_OFF_CTRL, {16'h0000, c});
        @(posedge pclk);
        go <= 1'h1;
        @(posedge pclk);
        go <= 1'h0;
        @(posedge pclk);
        i = 0;
        while (busy !== 1'h0 && i < 400) begin
            @(posedge pclk);
            i++;
        end
        if (i >= 400) begin
            failures++;
            tally_and_finish();
        end
        repeat (8) @(posedge pclk);
        caps = exp_caps(m, n, stop & cpu_idle);
        c[3] = caps > 0;
        c[4] = caps > DEPTH;
        ist = {m == 3'h7 && (cpu_sleep || cpu_idle) && n > 0, caps > DEPTH,
            caps > 0 && caps >= ((m == 3'h1) ? 1 : captures_per_interrupt + 1)};
        `CHK("irq", |(ist & msk), irq)
        chk_rd("ctrl", `ICC_OFF_CTRL, {16'h0000, c});
        chk_rd("istat", `ICC_OFF_ISTAT, {29'h0000_0000, ist});
        for (i = 0; i <= DEPTH; i++) begin
            prev = rdv[15:0];
            apb(1'h0, `ICC_OFF_BUF, 32'h0000_0000, rdv, erv);
            if (t != 3'h7 || i >= caps || i >= DEPTH) begin
                `CHK("buf", ((i < caps && i < DEPTH) ? {16'h0000, exp_val(t)} : 32'h0000_0000), rdv)
            end else if (i > 0) begin
                `CHK("buf_step", ((m == 3'h1) ? 16'h0004 : 16'h0008), rdv[15:0] - prev)
            end
        end
        c[4:3] = 2'h0;
        chk_rd("ctrl_drained", `ICC_OFF_CTRL, {16'h0000, c});
        `CHK("irq_clear", 1'h0, irq)
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        chk_rd("ctrl_rst", `ICC_OFF_CTRL, 32'h0000_0000);
        chk_rd("istat_rst", `ICC_OFF_ISTAT, 32'h0000_0000);
        chk_rd("imask_rst", `ICC_OFF_IMASK, 32'h0000_0000);
        apb(1'h0, 8'h10, 32'h0000_0000, rdv, erv);
        `CHK("slverr", 1'h1, erv)
        wr(`ICC_OFF_CTRL, 32'hFFFF_FFFF);
        chk_rd("ctrl_wmask", `ICC_OFF_CTRL, {16'h0000, `ICC_CTRL_WMASK});
        for (int k = 0; k < 14; k++) begin
            seed = lfsr(seed);
            run_case(k < 8 ? 3'(k) : seed[2:0], 3'((k + seed[3:0]) % 5), seed[9:8], 1'h0,
                k < 8 ? 16 : 1 + int'(seed[14:10]));
        end
        run_case(3'h3, 3'h5, 2'h0, 1'h0, 2);
        run_case(3'h3, 3'h7, 2'h0, 1'h0, 3);
        run_case(3'h1, 3'h7, 2'h2, 1'h0, 2);
        @(posedge pclk);
        cpu_idle <= 1'h1;
        run_case(3'h3, 3'h4, 2'h0, 1'h1, 3);
        run_case(3'h2, 3'h2, 2'h1, 1'h0, 3);
        run_case(3'h7, 3'h0, 2'h0, 1'h1, 2);
        @(posedge pclk);
        cpu_idle <= 1'h0;
        cpu_sleep <= 1'h1;
        run_case(3'h7, 3'h1, 2'h3, 1'h0, 2);
        @(posedge pclk);
        cpu_sleep <= 1'h0;
        run_case(3'h7, 3'h3, 2'h0, 1'h0, 2);
        tally_and_finish();
    end
endmodule
